// ---- rtl/cgfs_top.sv ----
// Operation
// - general output line follows the output drive setting, high or low.
// - input level status reads true when the general input line is high.
// - an event is emitted on each change of the general input line while route, source and delivery selects are 0x02, 0x05 and 0x03.
// - debounce setting gives a filter window in steps of about 480 ns.
// - debounce setting resets to zero; zero disables filtering.
// - debounce setting reaches 65535, about 31 ms of hold.
// - sync channel aligns frame start between leader and follower.
// - sync pulses at least 100 ns wide (the pin filter here accepts pulses of 2 clocks, 20 ns); accepted pulses stretched to 1 us.
// - sync mode is not retained; reset brings it back disabled.
// - slow configuration frames on a fraction of sync pulses.
// - relaying leader forwards incoming sync to sync out; follower does not.
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "cgfs_params.svh"
module cgfs_top #(
  parameter int unsigned DEB_W    = `CGFS_DEB_W,
  parameter int unsigned STEP_CYC = `CGFS_STEP_CYC,
  parameter int unsigned STR_CYC  = `CGFS_STRETCH_CYC
) (
  input  wire logic                      i_sys_clk,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_psel,
  input  wire logic                      i_penable,
  input  wire logic                      i_pwrite,
  input  wire logic [`CGFS_ADDR_W-1:0]   i_paddr,
  input  wire logic [31:0]               i_pwdata,
  output var  logic [31:0]               o_prdata,
  output var  logic                      o_pready,
  output var  logic                      o_pslverr,
  input  wire logic                      i_general_input_line,
  input  wire logic                      i_sync_in,
  input  wire logic                      i_frame_tick,
  output var  logic                      o_general_output_line,
  output var  logic                      o_input_change_event,
  output var  logic                      o_sync_out,
  output var  logic                      o_frame_start,
  output var  cgfs_pkg::cgfs_sync_mode_e o_sync_mode
);
  import cgfs_pkg::*;

  // ----------------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------------
  function automatic logic [3:0] cgfs_decode(
    input logic [`CGFS_ADDR_W-1:0] addr
  );
    logic [3:0] idx;
    idx = `CGFS_IDX_NONE;
    case (addr)
      `CGFS_OFF_CTRL:     idx = `CGFS_IDX_CTRL;
      `CGFS_OFF_STATUS:   idx = `CGFS_IDX_STATUS;
      `CGFS_OFF_DEBOUNCE: idx = `CGFS_IDX_DEBOUNCE;
      `CGFS_OFF_ROUTE:    idx = `CGFS_IDX_ROUTE;
      `CGFS_OFF_SOURCE:   idx = `CGFS_IDX_SOURCE;
      `CGFS_OFF_DELIVERY: idx = `CGFS_IDX_DELIVERY;
      `CGFS_OFF_SYNC:     idx = `CGFS_IDX_SYNC;
      `CGFS_OFF_EVCOUNT:  idx = `CGFS_IDX_EVCOUNT;
      default:            idx = `CGFS_IDX_NONE;
    endcase
    return idx;
  endfunction : cgfs_decode

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic                    drive_setting;
  logic [DEB_W-1:0]        debounce_setting;
  logic [`CGFS_SEL_W-1:0]  route_select;
  logic [`CGFS_SEL_W-1:0]  source_select;
  logic [`CGFS_SEL_W-1:0]  delivery_select;
  logic                    slow_enable;
  logic [`CGFS_DIV_W-1:0]  slow_divide;
  logic [`CGFS_DIV_W-1:0]  pulse_count;
  logic [`CGFS_EVC_W-1:0]  event_count;
  logic [1:0]              pin_s1;
  logic [1:0]              pin_s2;
  logic [1:0]              pin_s3;
  logic [1:0]              pin_clean;
  logic                    input_filtered;
  logic                    input_prev;
  logic                    sync_prev;
  logic                    stretched;

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  wire        apb_setup  = i_psel & ~i_penable;
  wire        apb_commit = i_psel & i_penable & o_pready;
  wire        apb_wr     = apb_commit & i_pwrite;
  wire [3:0]  wr_idx     = cgfs_decode(i_paddr);
  wire [3:0]  rd_idx     = cgfs_decode(i_paddr);
  wire        rd_bad     = rd_idx == `CGFS_IDX_NONE;
  wire        wr_ctrl    = apb_wr & (wr_idx == `CGFS_IDX_CTRL);
  wire        wr_deb     = apb_wr & (wr_idx == `CGFS_IDX_DEBOUNCE);
  wire        wr_route   = apb_wr & (wr_idx == `CGFS_IDX_ROUTE);
  wire        wr_source  = apb_wr & (wr_idx == `CGFS_IDX_SOURCE);
  wire        wr_deliver = apb_wr & (wr_idx == `CGFS_IDX_DELIVERY);
  wire        wr_sync    = apb_wr & (wr_idx == `CGFS_IDX_SYNC);

  wire [31:0] rd_ctrl    = {31'h0, drive_setting};
  wire [31:0] rd_status  = {29'h0, pin_clean[1], stretched,
                            input_filtered};
  wire [31:0] rd_deb     = {{(32-DEB_W){1'b0}}, debounce_setting};
  wire [31:0] rd_route   = {24'h0, route_select};
  wire [31:0] rd_source  = {24'h0, source_select};
  wire [31:0] rd_deliver = {24'h0, delivery_select};
  wire [31:0] rd_sync    = {20'h0, slow_divide, 3'h0, slow_enable, 2'h0,
                            o_sync_mode};
  wire [31:0] rd_evc     = {16'h0, event_count};

  wire [31:0] rd_word =
    (rd_idx == `CGFS_IDX_CTRL)     ? rd_ctrl    :
    (rd_idx == `CGFS_IDX_STATUS)   ? rd_status  :
    (rd_idx == `CGFS_IDX_DEBOUNCE) ? rd_deb     :
    (rd_idx == `CGFS_IDX_ROUTE)    ? rd_route   :
    (rd_idx == `CGFS_IDX_SOURCE)   ? rd_source  :
    (rd_idx == `CGFS_IDX_DELIVERY) ? rd_deliver :
    (rd_idx == `CGFS_IDX_SYNC)     ? rd_sync    :
    (rd_idx == `CGFS_IDX_EVCOUNT)  ? rd_evc     : 32'h0;

  wire cgfs_sync_mode_e wr_mode =
    cgfs_sync_mode_e'(i_pwdata[`CGFS_MODE_MSB:`CGFS_MODE_LSB]);

  // ----------------------------------------------------------------------
  // apb answer: ready in the first access cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0;
    end else begin
      o_pready  <= apb_setup;
      o_pslverr <= apb_setup & rd_bad;
      if (apb_setup & ~i_pwrite) begin
        o_prdata <= rd_word;
      end
    end
  end

  // ----------------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      drive_setting    <= 1'b0;
      debounce_setting <= '0;
      route_select     <= 8'h0;
      source_select    <= 8'h0;
      delivery_select  <= 8'h0;
      o_sync_mode      <= CGFS_SYNC_DISABLED;
      slow_enable      <= 1'b0;
      slow_divide      <= 4'h0;
    end else begin
      if (wr_ctrl) begin
        drive_setting <= i_pwdata[`CGFS_BIT_DRIVE];
      end
      if (wr_deb) begin
        debounce_setting <= i_pwdata[DEB_W-1:0];
      end
      if (wr_route) begin
        route_select <= i_pwdata[`CGFS_SEL_W-1:0];
      end
      if (wr_source) begin
        source_select <= i_pwdata[`CGFS_SEL_W-1:0];
      end
      if (wr_deliver) begin
        delivery_select <= i_pwdata[`CGFS_SEL_W-1:0];
      end
      if (wr_sync) begin
        o_sync_mode <= wr_mode;
        slow_enable <= i_pwdata[`CGFS_BIT_SLOW];
        slow_divide <= i_pwdata[`CGFS_DIV_MSB:`CGFS_DIV_LSB];
      end
    end
  end

  // ----------------------------------------------------------------------
  // general output
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_general_output_line <= 1'b0;
    end else begin
      o_general_output_line <= drive_setting;
    end
  end

  // ----------------------------------------------------------------------
  // pin synchronisers: bit 0 general input, bit 1 sync in
  // ----------------------------------------------------------------------
  wire [1:0] pin_raw   = {i_sync_in, i_general_input_line};
  wire [1:0] pin_agree = ~(pin_s2 ^ pin_s3);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_s1    <= 2'h0;
      pin_s2    <= 2'h0;
      pin_s3    <= 2'h0;
      pin_clean <= 2'h0;
    end else begin
      pin_s1    <= pin_raw;
      pin_s2    <= pin_s1;
      pin_s3    <= pin_s2;
      pin_clean <= (pin_agree & pin_s3) | (~pin_agree & pin_clean);
    end
  end

  // ----------------------------------------------------------------------
  // debounce and input events
  // ----------------------------------------------------------------------
  cgfs_debounce #(
    .CNT_W    (DEB_W),
    .STEP_CYC (STEP_CYC)
  ) u_debounce (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_level   (pin_clean[0]),
    .i_setting (debounce_setting),
    .o_level   (input_filtered)
  );

  wire events_on = (route_select == `CGFS_ROUTE_INPUT) &
                   (source_select == `CGFS_SOURCE_QUEUE) &
                   (delivery_select == `CGFS_DELIVER_NET);
  wire input_edge = input_filtered ^ input_prev;
  wire fire_event = input_edge & events_on;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      input_prev           <= 1'b0;
      o_input_change_event <= 1'b0;
      event_count          <= 16'h0;
    end else begin
      input_prev           <= input_filtered;
      o_input_change_event <= fire_event;
      if (fire_event) begin
        event_count <= 16'(event_count + 1'b1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // frame sync
  // ----------------------------------------------------------------------
  wire ext_pulse  = pin_clean[1] & ~sync_prev;
  wire mode_lead  = o_sync_mode == CGFS_SYNC_LEADER;
  wire mode_relay = o_sync_mode == CGFS_SYNC_RELAY_LEADER;
  wire mode_follw = o_sync_mode == CGFS_SYNC_FOLLOWER;
  wire ext_driven = mode_relay | mode_follw;
  wire div_hit    = ~slow_enable | (pulse_count == slow_divide);
  wire ext_frame  = ext_driven & ext_pulse & div_hit;
  wire int_frame  = ~ext_driven & i_frame_tick;
  wire out_trig   = (mode_lead & i_frame_tick) |
                    (mode_relay & ext_pulse);

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_prev     <= 1'b0;
      pulse_count   <= 4'h0;
      o_frame_start <= 1'b0;
    end else begin
      sync_prev     <= pin_clean[1];
      o_frame_start <= ext_frame | int_frame;
      if (~ext_driven | ~slow_enable) begin
        pulse_count <= 4'h0;
      end else if (ext_pulse) begin
        pulse_count <= div_hit ? 4'h0 : 4'(pulse_count + 1'b1);
      end
    end
  end

  cgfs_stretch #(
    .LEN_CYC (STR_CYC)
  ) u_stretch (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_trig    (out_trig),
    .o_pulse   (stretched)
  );

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sync_out <= 1'b0;
    end else begin
      o_sync_out <= stretched;
    end
  end

endmodule : cgfs_top
`default_nettype wire

// ---- rtl/cgfs_params.svh ----
`ifndef CGFS_PARAMS_SVH
`define CGFS_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------------
`define CGFS_ADDR_W         8
`define CGFS_OFF_CTRL       8'h00
`define CGFS_OFF_STATUS     8'h04
`define CGFS_OFF_DEBOUNCE   8'h08
`define CGFS_OFF_ROUTE      8'h0c
`define CGFS_OFF_SOURCE     8'h10
`define CGFS_OFF_DELIVERY   8'h14
`define CGFS_OFF_SYNC       8'h18
`define CGFS_OFF_EVCOUNT    8'h1c

// ----------------------------------------------------------------------
// register indices and field positions
// ----------------------------------------------------------------------
`define CGFS_IDX_CTRL       4'h0
`define CGFS_IDX_STATUS     4'h1
`define CGFS_IDX_DEBOUNCE   4'h2
`define CGFS_IDX_ROUTE      4'h3
`define CGFS_IDX_SOURCE     4'h4
`define CGFS_IDX_DELIVERY   4'h5
`define CGFS_IDX_SYNC       4'h6
`define CGFS_IDX_EVCOUNT    4'h7
`define CGFS_IDX_NONE       4'hf
`define CGFS_BIT_DRIVE      0
`define CGFS_BIT_IN_LEVEL   0
`define CGFS_BIT_SYNC_OUT   1
`define CGFS_BIT_SYNC_IN    2
`define CGFS_MODE_LSB       0
`define CGFS_MODE_MSB       1
`define CGFS_BIT_SLOW       4
`define CGFS_DIV_LSB        8
`define CGFS_DIV_MSB        11
`define CGFS_SEL_W          8
`define CGFS_DEB_W          16
`define CGFS_DIV_W          4
`define CGFS_EVC_W          16

// ----------------------------------------------------------------------
// event routing values
// ----------------------------------------------------------------------
`define CGFS_ROUTE_INPUT    8'h02
`define CGFS_SOURCE_QUEUE   8'h05
`define CGFS_DELIVER_NET    8'h03

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CGFS_CLK_NS         10
`define CGFS_STEP_NS        480
`define CGFS_STRETCH_NS     1000
`define CGFS_STEP_CYC       (`CGFS_STEP_NS / `CGFS_CLK_NS)
`define CGFS_STRETCH_CYC    ((`CGFS_STRETCH_NS + `CGFS_CLK_NS - 1) / `CGFS_CLK_NS)

`endif

// ---- rtl/cgfs_pkg.sv ----
`default_nettype none
package cgfs_pkg;
  typedef enum logic [1:0] {
    CGFS_SYNC_DISABLED,
    CGFS_SYNC_LEADER,
    CGFS_SYNC_RELAY_LEADER,
    CGFS_SYNC_FOLLOWER
  } cgfs_sync_mode_e;
endpackage : cgfs_pkg
`default_nettype wire

// ---- rtl/cgfs_debounce.sv ----
`timescale 1ns/100ps
`default_nettype none
module cgfs_debounce #(
  parameter int unsigned CNT_W    = 16,
  parameter int unsigned STEP_CYC = 48
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_level,
  input  wire logic [CNT_W-1:0] i_setting,
  output var  logic             o_level
);
  localparam int unsigned PRE_W = $clog2(STEP_CYC) + 1;

  logic [PRE_W-1:0] pre;
  logic [CNT_W-1:0] steps;
  wire              differ    = i_level != o_level;
  wire              step_done = pre == PRE_W'(STEP_CYC - 1);
  wire              bypass    = i_setting == '0;
  wire              win_done  = steps == CNT_W'(i_setting - 1'b1);

  // ----------------------------------------------------------------------
  // filter window in steps
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre     <= '0;
      steps   <= '0;
      o_level <= '0;
    end else if (bypass) begin
      pre     <= '0;
      steps   <= '0;
      o_level <= i_level;
    end else if (!differ) begin
      pre   <= '0;
      steps <= '0;
    end else if (!step_done) begin
      pre <= PRE_W'(pre + 1'b1);
    end else if (win_done) begin
      pre     <= '0;
      steps   <= '0;
      o_level <= i_level;
    end else begin
      pre   <= '0;
      steps <= CNT_W'(steps + 1'b1);
    end
  end
endmodule : cgfs_debounce
`default_nettype wire

// ---- rtl/cgfs_stretch.sv ----
`timescale 1ns/100ps
`default_nettype none
module cgfs_stretch #(
  parameter int unsigned LEN_CYC = 100
) (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_trig,
  output var  logic o_pulse
);
  localparam int unsigned CW = $clog2(LEN_CYC + 1);

  logic [CW-1:0] cnt;

  // ----------------------------------------------------------------------
  // hold high for the full stretch length, retrigger restarts
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt     <= '0;
      o_pulse <= '0;
    end else if (i_trig) begin
      cnt     <= CW'(LEN_CYC - 1);
      o_pulse <= 1'b1;
    end else if (cnt != '0) begin
      cnt <= CW'(cnt - 1'b1);
    end else begin
      o_pulse <= 1'b0;
    end
  end
endmodule : cgfs_stretch
`default_nettype wire

// ---- tb/cgfs_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "cgfs_params.svh"
// ----------------------------------------
// port checker
// ----------------------------------------
module cgfs_chk
  import cgfs_pkg::*;
#(
  parameter int unsigned STR_CYC = 100
) (
  input wire logic                      i_sys_clk,
  input wire logic                      i_rst_n,
  input wire logic                      i_psel,
  input wire logic                      i_penable,
  input wire logic                      i_pwrite,
  input wire logic [`CGFS_ADDR_W-1:0]   i_paddr,
  input wire logic [31:0]               i_pwdata,
  input wire logic                      o_pready,
  input wire logic                      o_pslverr,
  input wire logic                      i_frame_tick,
  input wire logic                      o_general_output_line,
  input wire logic                      o_input_change_event,
  input wire logic                      o_sync_out,
  input wire logic                      o_frame_start,
  input wire cgfs_pkg::cgfs_sync_mode_e o_sync_mode
);
  logic        drv;
  logic [15:0] run;
  wire  logic  commit;
  assign commit = i_psel & i_penable & o_pready;
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      drv <= 1'b0;
      run <= 16'h0000;
    end else begin
      if (commit && i_pwrite && i_paddr == 8'h00) drv <= i_pwdata[0];
      run <= o_sync_out ? run + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  ready_one_cycle_a: assert property (o_pready |=> !o_pready)
    else $error("pready held too long");
  ready_after_setup_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no pready after setup");
  err_with_ready_a: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  err_unmapped_a: assert property
    (i_psel && !i_penable && i_paddr >= 8'h20 |=> o_pslverr)
    else $error("unmapped access not refused");
  drive_follows_a: assert property (
    commit && i_pwrite && i_paddr == 8'h00 |-> ##2
    o_general_output_line == drv) else $error("output line wrong");
  mode_reset_off_a: assert property (
    $rose(i_rst_n) |-> o_sync_mode == CGFS_SYNC_DISABLED)
    else $error("sync mode not disabled after reset");
  event_pulse_a: assert property (
    o_input_change_event |=> !o_input_change_event)
    else $error("event pulse too long");
  frame_pulse_a: assert property (o_frame_start |=> !o_frame_start)
    else $error("frame start too long");
  stretch_len_a: assert property (
    $fell(o_sync_out) |-> run >= STR_CYC)
    else $error("sync out pulse too short");
  relay_src_a: assert property (
    $rose(o_sync_out) |->
    o_sync_mode inside {CGFS_SYNC_LEADER, CGFS_SYNC_RELAY_LEADER})
    else $error("sync out in wrong mode");
  idle_frame_a: assert property (
    o_sync_mode == CGFS_SYNC_DISABLED && i_frame_tick |-> ##[1:2]
    o_frame_start) else $error("frame tick not followed");
endmodule : cgfs_chk
bind cgfs_top cgfs_chk #(.STR_CYC(STR_CYC)) u_chk (
  .i_sys_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr,
  .i_pwdata, .o_pready, .o_pslverr, .i_frame_tick, .o_general_output_line,
  .o_input_change_event, .o_sync_out, .o_frame_start, .o_sync_mode);
`default_nettype wire

// ---- tb/cgfs_far_end.sv ----
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// control equipment and sync source
// ----------------------------------------
module cgfs_far_end (
  input  wire logic i_sys_clk,
  output var  logic o_line,
  output var  logic o_sync
);
  initial begin
    o_line = 1'b0;
    o_sync = 1'b0;
  end
  task automatic set_line(input logic v);
    @(posedge i_sys_clk);
    o_line <= v;
  endtask : set_line
  // pulse never under 10 cycles
  // caller sets the spacing between pulses
  task automatic sync_pulse(input int w);
    @(posedge i_sys_clk);
    o_sync <= 1'b1;
    repeat ((w < 10) ? 10 : w) @(posedge i_sys_clk);
    o_sync <= 1'b0;
  endtask : sync_pulse
endmodule : cgfs_far_end
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import cgfs_pkg::*;
  logic clk, rst_n, psel, penable;
  logic pwrite, tick, general_input_line, sync_in;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata, v;
  logic [31:0] seed = 32'h30476ab6;
  logic pready, pslverr, rerr, gol, ev, so, fs;
  cgfs_sync_mode_e mode;
  int fail_count = 0, n_checks = 0;
  int n_ev = 0, n_fs = 0, n_so = 0, hw = 0, last_w = 0, e0, f0, s0;
  always #5 clk = ~clk;
  cgfs_top #(.STEP_CYC(4), .STR_CYC(100)) dut (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_general_input_line(general_input_line), .i_sync_in(sync_in), .i_frame_tick(tick),
    .o_general_output_line(gol), .o_input_change_event(ev),
    .o_sync_out(so), .o_frame_start(fs), .o_sync_mode(mode));
  cgfs_far_end far (.i_sys_clk(clk), .o_line(general_input_line), .o_sync(sync_in));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int exp_out(input int m);
    return (m == 1 || m == 2) ? 1 : 0;
  endfunction : exp_out
  function automatic int slow_frames(input int n, input int d);
    int c;
    c = 0;
    for (int k = 0; k < n; k++) if (k % (d + 1) == 0) c++;
    return c;
  endfunction : slow_frames
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      fail_count++;
      wrap_up();
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdata, e);
  endtask : rdc
  task automatic toggle();
    far.set_line(1'b1);
    cyc(20);
    far.set_line(1'b0);
    cyc(20);
  endtask : toggle
  always @(posedge clk) begin
    if (ev === 1'b1) n_ev++;
    if (fs === 1'b1) n_fs++;
    if (so === 1'b1) hw++;
    else if (hw != 0) begin
      n_so++;
      last_w = hw;
      hw = 0;
    end
  end
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    rst_n <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    tick <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    cyc(6);
    rst_n <= 1'b1;
    rdc(8'h08, 32'h0);
    rdc(8'h18, 32'h0);
    chk(32'(mode), 32'(CGFS_SYNC_DISABLED));
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      wr(8'h00, v);
      cyc(3);
      chk(32'(gol), 32'(v[0]));
    end
    $display("drive done");
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      far.set_line(v[0]);
      cyc(8);
      rdc(8'h04, 32'(v[0]));
    end
    far.set_line(1'b0);
    cyc(10);
    $display("level done");
    wr(8'h0c, 32'h2);
    wr(8'h10, 32'h5);
    e0 = n_ev;
    toggle();
    chk(n_ev - e0, 0);
    wr(8'h14, 32'h3);
    e0 = n_ev;
    toggle();
    chk(n_ev - e0, 2);
    $display("event done");
    wr(8'h08, 32'h3);
    rdc(8'h08, 32'h3);
    e0 = n_ev;
    far.set_line(1'b1);
    cyc(6);
    far.set_line(1'b0);
    cyc(30);
    chk(n_ev - e0, 0);
    far.set_line(1'b1);
    cyc(40);
    rdc(8'h04, 32'h1);
    chk(n_ev - e0, 1);
    rdc(8'h1c, 32'h3);
    wr(8'h08, 32'hffff_ffff);
    rdc(8'h08, 32'h0000_ffff);
    $display("debounce done");
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(rerr), 32'h1);
    chk(rdata, 32'h0);
    for (int m = 0; m < 4; m++) begin
      wr(8'h18, 32'(m));
      cyc(1);
      chk(32'(mode), 32'(m));
      f0 = n_fs;
      s0 = n_so;
      v = rnd();
      far.sync_pulse(10 + int'(v[2:0]));
      cyc(150);
      @(posedge clk) tick <= 1'b1;
      @(posedge clk) tick <= 1'b0;
      cyc(150);
      chk(n_fs - f0, 1);
      chk(n_so - s0, exp_out(m));
      if (exp_out(m) == 1) chk(last_w, 100);
    end
    $display("sync done");
    wr(8'h18, 32'h0000_0112);
    rdc(8'h18, 32'h0000_0112);
    f0 = n_fs;
    for (int k = 0; k < 4; k++) begin
      far.sync_pulse(12);
      cyc(120);
    end
    chk(n_fs - f0, slow_frames(4, 1));
    $display("slow done");
    wr(8'h08, 32'h5);
    @(posedge clk) rst_n <= 1'b0;
    cyc(3);
    @(posedge clk) rst_n <= 1'b1;
    rdc(8'h18, 32'h0);
    chk(32'(mode), 32'(CGFS_SYNC_DISABLED));
    rdc(8'h08, 32'h0);
    $display("reset done");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
